// File: bench/fbs_master_model.sv
/*
  Behavioural master station on the far side of the fieldbus.
  Assumes the slave's rate code and join permission arrive on MCLK.
*/
`timescale 1ns/10ps
`default_nettype none

module fbs_master_model (
  input  wire logic       clk,        // System clock
  input  wire logic       rst_b,      // Async reset
  input  wire logic       net_en,     // Slave may join
  input  wire logic [1:0] slave_rate, // Slave rate code
  input  wire logic [1:0] bus_rate,   // Rate the master runs
  input  wire logic       want_conn,  // Master opens a link
  input  wire logic       drop_conn,  // Master stops polling
  output logic            online,     // Slave present on bus
  output logic            connected,  // Link open
  output logic            link_err,   // Frames garbled
  output logic            conn_tmo    // Poll timed out
);
  logic match;

  assign match = net_en && (slave_rate == bus_rate);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      online    <= 1'b0;
      connected <= 1'b0;
      link_err  <= 1'b0;
      conn_tmo  <= 1'b0;
    end
    else
    begin
      online    <= net_en;
      connected <= match && want_conn && !drop_conn;
      // A wrong rate garbles frames rather than looking like silence
      link_err  <= net_en && !match;
      conn_tmo  <= match && drop_conn;
    end
  end
endmodule // fbs_master_model

`default_nettype wire

// File: bench/tb_fbs_top.sv
/*
  Self-checking bench for the fieldbus slave configuration block.
  Assumes fbs_defines.svh on the include path and the master model.
*/
`include "fbs_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_fbs_top;
  logic       MCLK, RST_B, RATE_SWITCH_HIGH, RATE_SWITCH_LOW;
  logic [5:0] ADDRESS_SWITCH, NODE_ADDR;
  logic       COMM_POWER, DEV_POWER, ONLINE, CONNECTED, LINK_ERR, CONN_TMO;
  logic       CRIT_ERR, OTHER_ERR, AWVALID, AWREADY, WVALID, WREADY;
  logic       BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, RATE_SEL, bus_rate;
  logic       NET_ENABLE, NS_GREEN, NS_RED, MS_GREEN, MS_RED, IRQ;
  logic       want_conn, drop_conn;
  int         failures, check_count;
  logic [5:0] addr_list [5] = '{6'h00, 6'h01, 6'h02, 6'h3E, 6'h3F};

  fbs_top #(.BLINK_HALF_CYC(8)) i_fbs_top (.MCLK, .RST_B,
    .RATE_SWITCH_HIGH, .RATE_SWITCH_LOW, .ADDRESS_SWITCH, .COMM_POWER,
    .DEV_POWER, .ONLINE, .CONNECTED, .LINK_ERR, .CONN_TMO, .CRIT_ERR,
    .OTHER_ERR, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .NODE_ADDR, .RATE_SEL, .NET_ENABLE,
    .NS_GREEN, .NS_RED, .MS_GREEN, .MS_RED, .IRQ);

  fbs_master_model i_fbs_master_model (.clk(MCLK), .rst_b(RST_B),
    .net_en(NET_ENABLE), .slave_rate(RATE_SEL), .bus_rate, .want_conn,
    .drop_conn, .online(ONLINE), .connected(CONNECTED),
    .link_err(LINK_ERR), .conn_tmo(CONN_TMO));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Longer than switch sync plus model and indicator delays
  task automatic settle;
    repeat (8) @(posedge MCLK);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_done;
    logic w_done;
    // One edge between transfers so no strobe is driven twice at once
    @(posedge MCLK);
    aw_done = 1'b0;
    w_done = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge MCLK);
      aw_done = aw_done || (AWREADY === 1'b1);
      w_done = w_done || (WREADY === 1'b1);
      AWVALID <= !aw_done;
      WVALID <= !w_done;
    end
    do @(posedge MCLK); while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge MCLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge MCLK); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d & m, e);
  endtask

  task automatic set_net(input logic cp, input logic want, input logic drop,
                         input logic [1:0] br, input logic [2:0] ns);
    COMM_POWER <= cp;
    want_conn <= want;
    drop_conn <= drop;
    bus_rate <= br;
    settle();
    rdchk(`FBS_REG_LINK_STAT, 32'h7, {29'h0, ns});
  endtask

  task automatic set_mod(input logic dp, input logic crit, input logic oth,
                         input logic [2:0] ms);
    DEV_POWER <= dp;
    CRIT_ERR <= crit;
    OTHER_ERR <= oth;
    settle();
    rdchk(`FBS_REG_LINK_STAT, 32'h70, {25'h0, ms, 4'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  initial
  begin
    repeat (20000) @(posedge MCLK);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    RST_B = 1'b0;
    {RATE_SWITCH_HIGH, RATE_SWITCH_LOW} = 2'h0;
    ADDRESS_SWITCH = 6'h3F;
    {COMM_POWER, DEV_POWER, CRIT_ERR, OTHER_ERR} = 4'hC;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
    {bus_rate, want_conn, drop_conn} = 4'h0;
    {failures, check_count} = 64'h0;
    repeat (5) @(posedge MCLK);
    RST_B <= 1'b1;
    settle();
    rdchk(`FBS_REG_IN_SIZE, 32'h3FF, 32'h020);
    rdchk(`FBS_REG_OUT_SIZE, 32'h3FF, 32'h020);
    rdchk(`FBS_REG_MAP_IN, 32'hFFFFFFFF, 32'h02FF0200);
    rdchk(`FBS_REG_MAP_OUT, 32'hFFFFFFFF, 32'h02FF0200);
    foreach (addr_list[i])
    begin
      ADDRESS_SWITCH <= addr_list[i];
      settle();
      chk({26'h0, NODE_ADDR}, {26'h0, addr_list[i]});
      rdchk(`FBS_REG_IDENT, 32'h3F, {26'h0, addr_list[i]});
    end
    for (int i = 3; i >= 0; i--)
    begin
      {RATE_SWITCH_HIGH, RATE_SWITCH_LOW} <= 2'(i);
      settle();
      chk({30'h0, RATE_SEL}, 32'(i));
      chk({31'h0, NET_ENABLE}, {31'h0, i != 3});
      d = (32'(i) << 8) | ((i == 3) ? 32'h400 : 32'h0);
      rdchk(`FBS_REG_IDENT, 32'h700, d);
      if (i == 3)
        rdchk(`FBS_REG_LINK_STAT, 32'h177, 32'h020);
    end
    set_net(1'b0, 1'b1, 1'b0, 2'h0, 3'h0);
    set_net(1'b1, 1'b0, 1'b0, 2'h0, 3'h3);
    set_net(1'b1, 1'b1, 1'b0, 2'h0, 3'h1);
    chk({30'h0, NS_GREEN, NS_RED}, 32'h2);
    set_net(1'b1, 1'b1, 1'b1, 2'h0, 3'h2);
    set_net(1'b1, 1'b1, 1'b0, 2'h1, 3'h6);
    chk({30'h0, NS_GREEN, NS_RED}, 32'h1);
    set_net(1'b1, 1'b1, 1'b0, 2'h0, 3'h1);
    set_mod(1'b0, 1'b0, 1'b0, 3'h0);
    set_mod(1'b1, 1'b1, 1'b1, 3'h6);
    set_mod(1'b1, 1'b0, 1'b1, 3'h2);
    set_mod(1'b1, 1'b0, 1'b0, 3'h1);
    chk({30'h0, MS_GREEN, MS_RED}, 32'h2);
    // Interrupt path rides on the size error edge
    axi_wr(`FBS_REG_IRQ_MASK, 32'h2, r);
    axi_wr(`FBS_REG_IRQ_STAT, 32'hF, r);
    settle();
    chk({31'h0, IRQ}, 32'h0);
    axi_wr(`FBS_REG_IN_SIZE, 32'h100, r);
    settle();
    rdchk(`FBS_REG_LINK_STAT, 32'h270, 32'h010);
    rdchk(`FBS_REG_MAP_IN, 32'hFFFFFFFF, 32'h09FF0200);
    axi_wr(`FBS_REG_IN_SIZE, 32'h101, r);
    settle();
    rdchk(`FBS_REG_LINK_STAT, 32'h270, 32'h230);
    rdchk(`FBS_REG_IRQ_STAT, 32'hF, 32'h2);
    chk({31'h0, IRQ}, 32'h1);
    axi_wr(`FBS_REG_IRQ_MASK, 32'h0, r);
    settle();
    chk({31'h0, IRQ}, 32'h0);
    axi_wr(`FBS_REG_IRQ_MASK, 32'h2, r);
    settle();
    chk({31'h0, IRQ}, 32'h1);
    axi_wr(`FBS_REG_IRQ_STAT, 32'h2, r);
    settle();
    chk({31'h0, IRQ}, 32'h0);
    axi_wr(`FBS_REG_IN_SIZE, 32'h020, r);
    axi_wr(`FBS_REG_OUT_SIZE, 32'h101, r);
    settle();
    rdchk(`FBS_REG_LINK_STAT, 32'h200, 32'h200);
    axi_rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, `FBS_RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(8'h40, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, `FBS_RESP_SLVERR});
    give_verdict();
  end
endmodule // tb_fbs_top

`default_nettype wire

// File: design/fbs_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the
  fieldbus slave configuration and status block.
  Assumes a 25 MHz system clock and an 8-bit AXI4-Lite byte address.
*/
`ifndef FBS_DEFINES_SVH
`define FBS_DEFINES_SVH

`define FBS_SW_W           8
`define FBS_ADDR_W         6
`define FBS_SIZE_W         10
`define FBS_AXI_AW         8
`define FBS_IRQ_W          4
`define FBS_BLINK_W        24

`define FBS_REG_IDENT      8'h00
`define FBS_REG_IN_SIZE    8'h04
`define FBS_REG_OUT_SIZE   8'h08
`define FBS_REG_MAP_IN     8'h0C
`define FBS_REG_MAP_OUT    8'h10
`define FBS_REG_LINK_STAT  8'h14
`define FBS_REG_IRQ_STAT   8'h18
`define FBS_REG_IRQ_MASK   8'h1C

`define FBS_ID_RATE_LSB    8
`define FBS_ID_BAD_BIT     10
`define FBS_LS_MS_LSB      4
`define FBS_LS_NETEN_BIT   8
`define FBS_LS_SIZEERR_BIT 9

`define FBS_IRQ_SWITCH     0
`define FBS_IRQ_SIZE       1
`define FBS_IRQ_LINK       2
`define FBS_IRQ_TMO        3

`define FBS_SW_RST         8'h3F
`define FBS_SIZE_RST       10'h020
`define FBS_SIZE_MAX       10'h100
`define FBS_MAP_BASE       16'h0200

`define FBS_RESP_OKAY      2'h0
`define FBS_RESP_SLVERR    2'h2

`define FBS_CLK_HZ         25000000
`define FBS_BLINK_HALF_MS  500
`define FBS_BLINK_HALF_CYC (`FBS_BLINK_HALF_MS * (`FBS_CLK_HZ / 1000))

`endif

// File: design/fbs_pkg.sv
/*
  Types for the fieldbus slave configuration and status block.
  Assumes fbs_defines.svh on the include path.
*/
`include "fbs_defines.svh"

package fbs_pkg;

  typedef enum logic [1:0] {
    RATE_125K = 2'h0,
    RATE_250K = 2'h1,
    RATE_500K = 2'h2,
    RATE_BAD  = 2'h3
  } fbs_rate_type;

  // Gray order from dark through the error modes
  typedef enum logic [2:0] {
    LED_OFF         = 3'h0,
    LED_GREEN       = 3'h1,
    LED_GREEN_BLINK = 3'h3,
    LED_RED_BLINK   = 3'h2,
    LED_RED         = 3'h6
  } fbs_led_type;

  typedef struct packed {
    logic [`FBS_SW_W-1:0]    sync1;
    logic [`FBS_SW_W-1:0]    sync2;
    logic [`FBS_SW_W-1:0]    sync3;
    logic [`FBS_SW_W-1:0]    sw;
    logic [`FBS_SIZE_W-1:0]  in_size;
    logic [`FBS_SIZE_W-1:0]  out_size;
    logic [`FBS_BLINK_W-1:0] blink_cnt;
    logic                    blink;
    logic                    size_err;
    logic                    link_err_d;
    logic                    tmo_d;
    logic [`FBS_IRQ_W-1:0]   irq_stat;
    logic [`FBS_IRQ_W-1:0]   irq_mask;
    logic                    irq;
    logic                    ns_g;
    logic                    ns_r;
    logic                    ms_g;
    logic                    ms_r;
    logic                    net_en;
    logic                    aw_rdy;
    logic                    w_rdy;
    logic                    aw_hold;
    logic                    w_hold;
    logic [`FBS_AXI_AW-1:0]  aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    ar_rdy;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } fbs_state_type;

endpackage

// File: design/fbs_top.sv
/*
  Configuration-switch decoding, status indicators and AXI4-Lite register
  file of a fieldbus slave board.
  Assumes the switch pins are asynchronous and that the protocol engine
  status inputs come from logic on MCLK.
*/
`timescale 1ns/10ps
`default_nettype none

module fbs_top #(
  parameter int BLINK_HALF_CYC = `FBS_BLINK_HALF_CYC
) (
  input  wire logic                   MCLK,             // 25 MHz clock
  input  wire logic                   RST_B,            // Async reset
  input  wire logic                   RATE_SWITCH_HIGH, // Rate pos. one
  input  wire logic                   RATE_SWITCH_LOW,  // Rate pos. two
  input  wire logic [`FBS_ADDR_W-1:0] ADDRESS_SWITCH,   // Bit5 msb pos.
  input  wire logic                   COMM_POWER,       // Bus power ok
  input  wire logic                   DEV_POWER,        // Device power
  input  wire logic                   ONLINE,           // Node online
  input  wire logic                   CONNECTED,        // Connection up
  input  wire logic                   LINK_ERR,         // Link failure
  input  wire logic                   CONN_TMO,         // Conn timeout
  input  wire logic                   CRIT_ERR,         // Critical fault
  input  wire logic                   OTHER_ERR,        // Minor fault
  input  wire logic [`FBS_AXI_AW-1:0] AWADDR,           // Write address
  input  wire logic                   AWVALID,          // Addr valid
  output logic                        AWREADY,          // Addr ready
  input  wire logic [31:0]            WDATA,            // Write data
  input  wire logic [3:0]             WSTRB,            // Byte enables
  input  wire logic                   WVALID,           // Data valid
  output logic                        WREADY,           // Data ready
  output logic [1:0]                  BRESP,            // Write response
  output logic                        BVALID,           // Resp valid
  input  wire logic                   BREADY,           // Resp ready
  input  wire logic [`FBS_AXI_AW-1:0] ARADDR,           // Read address
  input  wire logic                   ARVALID,          // Addr valid
  output logic                        ARREADY,          // Addr ready
  output logic [31:0]                 RDATA,            // Read data
  output logic [1:0]                  RRESP,            // Read response
  output logic                        RVALID,           // Data valid
  input  wire logic                   RREADY,           // Data ready
  output logic [`FBS_ADDR_W-1:0]      NODE_ADDR,        // Node address
  output logic [1:0]                  RATE_SEL,         // Rate code
  output logic                        NET_ENABLE,       // May join bus
  output logic                        NS_GREEN,         // Network green
  output logic                        NS_RED,           // Network red
  output logic                        MS_GREEN,         // Module green
  output logic                        MS_RED,           // Module red
  output logic                        IRQ               // Interrupt
);

  fbs_pkg::fbs_state_type st;
  fbs_pkg::fbs_state_type nx;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_hit(input logic [`FBS_AXI_AW-1:0] a);
    case (a)
      `FBS_REG_IDENT, `FBS_REG_IN_SIZE, `FBS_REG_OUT_SIZE,
      `FBS_REG_MAP_IN, `FBS_REG_MAP_OUT, `FBS_REG_LINK_STAT,
      `FBS_REG_IRQ_STAT, `FBS_REG_IRQ_MASK: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [`FBS_SIZE_W-1:0] size_merge(
    input logic [`FBS_SIZE_W-1:0] old,
    input logic [31:0]            d,
    input logic [3:0]             s
  );
    size_merge = old;
    if (s[0])
    begin
      size_merge[7:0] = d[7:0];
    end
    if (s[1])
    begin
      size_merge[`FBS_SIZE_W-1:8] = d[`FBS_SIZE_W-1:8];
    end
  endfunction

  // First and last host bit of a process image of the given byte count
  function automatic logic [31:0] map_word(
    input logic [`FBS_SIZE_W-1:0] size
  );
    logic [15:0] last;
    last = 16'(`FBS_MAP_BASE + {3'h0, size, 3'h0} - 16'h0001);
    map_word = {last, `FBS_MAP_BASE};
  endfunction

  function automatic fbs_pkg::fbs_led_type ns_mode(
    input logic pwr, input logic online, input logic conn,
    input logic lerr, input logic tmo, input logic bad
  );
    if (!pwr || !online || bad)
      ns_mode = fbs_pkg::LED_OFF;
    else if (lerr)
      ns_mode = fbs_pkg::LED_RED;
    else if (tmo)
      ns_mode = fbs_pkg::LED_RED_BLINK;
    else if (conn)
      ns_mode = fbs_pkg::LED_GREEN;
    else
      ns_mode = fbs_pkg::LED_GREEN_BLINK;
  endfunction

  function automatic fbs_pkg::fbs_led_type ms_mode(
    input logic pwr, input logic crit, input logic other,
    input logic bad, input logic serr
  );
    if (!pwr)
      ms_mode = fbs_pkg::LED_OFF;
    else if (crit)
      ms_mode = fbs_pkg::LED_RED;
    else if (bad || other)
      ms_mode = fbs_pkg::LED_RED_BLINK;
    else if (serr)
      ms_mode = fbs_pkg::LED_GREEN_BLINK;
    else
      ms_mode = fbs_pkg::LED_GREEN;
  endfunction

  // Returns {green, red}
  function automatic logic [1:0] led_drive(
    input fbs_pkg::fbs_led_type m, input logic ph
  );
    unique case (m)
      fbs_pkg::LED_OFF:         led_drive = 2'h0;
      fbs_pkg::LED_GREEN:       led_drive = 2'h2;
      fbs_pkg::LED_GREEN_BLINK: led_drive = {ph, 1'b0};
      fbs_pkg::LED_RED_BLINK:   led_drive = {1'b0, ph};
      fbs_pkg::LED_RED:         led_drive = 2'h1;
      default:                  led_drive = 2'h0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic                  sw_chg;
    logic                  bad;
    logic                  serr;
    logic [`FBS_IRQ_W-1:0] ev;
    logic [`FBS_IRQ_W-1:0] clr;
    fbs_pkg::fbs_led_type  nsm;
    fbs_pkg::fbs_led_type  msm;
    sw_chg = 1'b0;
    bad    = 1'b0;
    serr   = 1'b0;
    nsm    = fbs_pkg::LED_OFF;
    msm    = fbs_pkg::LED_OFF;
    ev     = '0;
    clr    = '0;
    nx     = st;

    // Switch value is taken once the last two stages agree
    nx.sync1 = {RATE_SWITCH_HIGH, RATE_SWITCH_LOW, ADDRESS_SWITCH};
    nx.sync2 = st.sync1;
    nx.sync3 = st.sync2;
    if (st.sync2 == st.sync3)
    begin
      nx.sw  = st.sync3;
      sw_chg = (st.sync3 != st.sw);
    end

    // Common 1 Hz blink phase shared by both indicators
    if (st.blink_cnt == `FBS_BLINK_W'(BLINK_HALF_CYC - 1))
    begin
      nx.blink_cnt = '0;
      nx.blink     = ~st.blink;
    end
    else
    begin
      nx.blink_cnt = st.blink_cnt + `FBS_BLINK_W'(1);
    end

    bad  = (st.sw[7:6] == fbs_pkg::RATE_BAD);
    serr = (st.in_size > `FBS_SIZE_MAX) ||
           (st.out_size > `FBS_SIZE_MAX);
    nx.size_err   = serr;
    nx.link_err_d = LINK_ERR;
    nx.tmo_d      = CONN_TMO;
    nx.net_en     = !bad;

    nsm = ns_mode(COMM_POWER, ONLINE, CONNECTED, LINK_ERR, CONN_TMO, bad);
    msm = ms_mode(DEV_POWER, CRIT_ERR, OTHER_ERR, bad, serr);
    {nx.ns_g, nx.ns_r} = led_drive(nsm, st.blink);
    {nx.ms_g, nx.ms_r} = led_drive(msm, st.blink);

    ev[`FBS_IRQ_SWITCH] = sw_chg;
    ev[`FBS_IRQ_SIZE]   = serr && !st.size_err;
    ev[`FBS_IRQ_LINK]   = LINK_ERR && !st.link_err_d;
    ev[`FBS_IRQ_TMO]    = CONN_TMO && !st.tmo_d;

    // Write channel: address and data may arrive in either order
    if (AWVALID && st.aw_rdy)
    begin
      nx.aw_rdy  = 1'b0;
      nx.aw_hold = 1'b1;
      nx.aw_addr = AWADDR;
    end
    if (WVALID && st.w_rdy)
    begin
      nx.w_rdy  = 1'b0;
      nx.w_hold = 1'b1;
      nx.w_data = WDATA;
      nx.w_strb = WSTRB;
    end
    if (st.aw_hold && st.w_hold)
    begin
      nx.aw_hold = 1'b0;
      nx.w_hold  = 1'b0;
      nx.bvalid  = 1'b1;
      nx.bresp   = reg_hit(st.aw_addr) ? `FBS_RESP_OKAY : `FBS_RESP_SLVERR;
      case (st.aw_addr)
        `FBS_REG_IN_SIZE:
          nx.in_size = size_merge(st.in_size, st.w_data, st.w_strb);
        `FBS_REG_OUT_SIZE:
          nx.out_size = size_merge(st.out_size, st.w_data, st.w_strb);
        `FBS_REG_IRQ_STAT:
          clr = st.w_strb[0] ? st.w_data[`FBS_IRQ_W-1:0] : '0;
        `FBS_REG_IRQ_MASK:
          if (st.w_strb[0])
          begin
            nx.irq_mask = st.w_data[`FBS_IRQ_W-1:0];
          end
        default: ;
      endcase
    end
    if (st.bvalid && BREADY)
    begin
      nx.bvalid = 1'b0;
      nx.aw_rdy = 1'b1;
      nx.w_rdy  = 1'b1;
    end

    // A new event outweighs a clear in the same cycle
    nx.irq_stat = (st.irq_stat & ~clr) | ev;
    nx.irq      = |(nx.irq_stat & nx.irq_mask);

    // Read channel answers on the same edge that takes the address
    if (ARVALID && st.ar_rdy)
    begin
      nx.ar_rdy = 1'b0;
      nx.rvalid = 1'b1;
      nx.rdata  = '0;
      nx.rresp  = reg_hit(ARADDR) ? `FBS_RESP_OKAY : `FBS_RESP_SLVERR;
      case (ARADDR)
        `FBS_REG_IDENT:
        begin
          nx.rdata[`FBS_ADDR_W-1:0] = st.sw[5:0];
          nx.rdata[`FBS_ID_RATE_LSB+:2] = st.sw[7:6];
          nx.rdata[`FBS_ID_BAD_BIT] = bad;
        end
        `FBS_REG_IN_SIZE:   nx.rdata[`FBS_SIZE_W-1:0] = st.in_size;
        `FBS_REG_OUT_SIZE:  nx.rdata[`FBS_SIZE_W-1:0] = st.out_size;
        `FBS_REG_MAP_IN:    nx.rdata = map_word(st.in_size);
        `FBS_REG_MAP_OUT:   nx.rdata = map_word(st.out_size);
        `FBS_REG_LINK_STAT:
        begin
          nx.rdata[2:0] = nsm;
          nx.rdata[`FBS_LS_MS_LSB+:3] = msm;
          nx.rdata[`FBS_LS_NETEN_BIT] = st.net_en;
          nx.rdata[`FBS_LS_SIZEERR_BIT] = st.size_err;
        end
        `FBS_REG_IRQ_STAT:  nx.rdata[`FBS_IRQ_W-1:0] = st.irq_stat;
        `FBS_REG_IRQ_MASK:  nx.rdata[`FBS_IRQ_W-1:0] = st.irq_mask;
        default: ;
      endcase
    end
    if (st.rvalid && RREADY)
    begin
      nx.rvalid = 1'b0;
      nx.ar_rdy = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st          <= '0;
      st.sync1    <= `FBS_SW_RST;
      st.sync2    <= `FBS_SW_RST;
      st.sync3    <= `FBS_SW_RST;
      st.sw       <= `FBS_SW_RST;
      st.in_size  <= `FBS_SIZE_RST;
      st.out_size <= `FBS_SIZE_RST;
      st.aw_rdy   <= 1'b1;
      st.w_rdy    <= 1'b1;
      st.ar_rdy   <= 1'b1;
    end
    else
    begin
      st <= nx;
    end
  end

  assign AWREADY    = st.aw_rdy;
  assign WREADY     = st.w_rdy;
  assign BVALID     = st.bvalid;
  assign BRESP      = st.bresp;
  assign ARREADY    = st.ar_rdy;
  assign RVALID     = st.rvalid;
  assign RDATA      = st.rdata;
  assign RRESP      = st.rresp;
  assign NODE_ADDR  = st.sw[5:0];
  assign RATE_SEL   = st.sw[7:6];
  assign NET_ENABLE = st.net_en;
  assign NS_GREEN   = st.ns_g;
  assign NS_RED     = st.ns_r;
  assign MS_GREEN   = st.ms_g;
  assign MS_RED     = st.ms_r;
  assign IRQ        = st.irq;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  addr_from_switch_a:
    assert property ((st.sync2 == st.sync3) |=>
                     NODE_ADDR == $past(st.sync3[5:0]))
    else $error("node address does not follow settled switches");

  rate_from_switch_a:
    assert property ((st.sync2 == st.sync3) |=>
                     RATE_SEL == $past(st.sync3[7:6]))
    else $error("rate code does not follow settled switches");

  bad_rate_off_a:
    assert property ((st.sw[7:6] == 2'h3) && DEV_POWER && !CRIT_ERR |=>
                     !NET_ENABLE && !NS_GREEN && !NS_RED && !MS_GREEN)
    else $error("prohibited rate did not take node off the bus");

  ns_connected_a:
    assert property (COMM_POWER && ONLINE && CONNECTED && !LINK_ERR &&
                     !CONN_TMO && (st.sw[7:6] != 2'h3) |=>
                     NS_GREEN && !NS_RED)
    else $error("network indicator not steady green when connected");

  ns_link_err_a:
    assert property (COMM_POWER && ONLINE && LINK_ERR &&
                     (st.sw[7:6] != 2'h3) |=> NS_RED && !NS_GREEN)
    else $error("network indicator not steady red on link error");

  ms_critical_a:
    assert property (DEV_POWER && CRIT_ERR |=> MS_RED && !MS_GREEN)
    else $error("module indicator not steady red on critical error");

  ms_power_off_a:
    assert property (!DEV_POWER |=> !MS_RED && !MS_GREEN)
    else $error("module indicator lit without device power");

  size_err_flag_a:
    assert property ((st.in_size > 10'h100) && DEV_POWER && !CRIT_ERR &&
                     !OTHER_ERR && (st.sw[7:6] != 2'h3) |=>
                     !MS_RED && st.size_err)
    else $error("oversize image not shown as size error");

  size_err_irq_a:
    assert property ($rose(st.size_err) |-> st.irq_stat[1])
    else $error("size error did not raise its status bit");

  map_default_a:
    assert property (ARVALID && ARREADY && (ARADDR == 8'h0C) |=>
                     RVALID && (RDATA[15:0] == 16'h0200) &&
                     (RDATA[31:16] ==
                      16'(16'h01FF + {3'h0, $past(st.in_size), 3'h0})))
    else $error("input map read is not based at host bit 512");

  size_change_cause_a:
    assert property ((st.in_size != $past(st.in_size)) |->
                     $past(st.aw_hold && st.w_hold &&
                           (st.aw_addr == 8'h04)))
    else $error("input size changed without a host write");

  ident_read_a:
    assert property (ARVALID && ARREADY && (ARADDR == 8'h00) |=>
                     RDATA[5:0] == $past(st.sw[5:0]) &&
                     RDATA[9:8] == $past(st.sw[7:6]))
    else $error("identity read does not show switch address and rate");

  write_seen_c: cover property (AWVALID && AWREADY ##1 !AWREADY ##1 BVALID);
  bad_rate_c:   cover property (st.sw[7:6] == 2'h3 ##1 !NET_ENABLE);
  size_err_c:   cover property ($rose(st.size_err));
  blink_c:      cover property (MS_GREEN ##1 !MS_GREEN && !MS_RED);

endmodule // fbs_top

`default_nettype wire
